// ### src/pin_sync.sv
// three-stage input synchroniser, change accepted when stages two and three agree
module pin_sync #(
    parameter int    WIDTH = 3,
    parameter bit    INIT  = 1'b1
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_r     <= {WIDTH{INIT}};
            s2_r     <= {WIDTH{INIT}};
            s3_r     <= {WIDTH{INIT}};
            sync_out <= {WIDTH{INIT}};
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// ### src/spi_status_map.svh
// register offsets, field positions, reset values and timing counts of the serial block
`ifndef SPI_STATUS_MAP_SVH
`define SPI_STATUS_MAP_SVH
`define CTRL_IDX          8'h10
`define STATUS_IDX        8'h11
`define DATA_IDX          8'h12
`define CTRL_ADDR         12'h040
`define STATUS_ADDR       12'h044
`define DATA_ADDR         12'h048
`define ST_RXFULL         7
`define ST_ERROR_IRQ_ENABLE          6
`define ST_OVR            5
`define ST_FAULT          4
`define ST_TXEMPTY        3
`define ST_FDEN           2
`define CT_RXIE           7
`define CT_MASTER         5
`define CT_CPOL           4
`define CT_CLOCK_PHASE           3
`define CT_ENABLE         1
`define CT_TXIE           0
`define CTRL_RESET        8'h28
`define BAUD_RESET        2'h0
`define BITS_PER_BYTE     4'h8
`define BASE_CLK_MHZ      25
`define BASE_CYCLES       ((`BASE_CLK_MHZ * 40) / 1000)
`endif

// ### src/spi_status_pkg.sv
// types shared by the serial status block
package spi_status_pkg;
    typedef struct packed {
        logic        sel;
        logic        write;
        logic [11:0] addr;
    } bus_req_t;
    typedef struct packed {
        logic sclkOut;
        logic sclkOe;
        logic mosiOut;
        logic mosiOe;
        logic misoOut;
        logic misoOe;
    } pin_out_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } shift_state_t;
endpackage

// ### src/spi_status_port.sv
// serial status, flags, baud select and data port with an AHB-Lite register slave
// Behaviour
// R1 - byte into receive register sets rx full
// R2 - status read then data read clears rx full
// R3 - error enable gates overrun and fault requests
// R4 - overrun keeps old byte, drops new
// R5 - status read then data read clears overrun
// R6 - slave select rising mid-byte sets fault
// R7 - master sees select low, sets fault
// R8 - status read then control write clears fault
// R9 - handing byte to shifter sets tx empty
// R10 - data write clears tx empty; resets set
// R11 - software writes data only when empty
// R12 - fault enable gates setting, never clearing
// R13 - master without detection ignores slave select
// R14 - slave always uses select as input
// R15 - baud code picks divisor 2/8/32/128
// R16 - serial clock is base over twice divisor
// R17 - data writes go transmit, reads receive
// R18 - reset leaves data registers untouched
// R19 - software avoids read-modify-write on data
// R20 - deselected slave floats output, ignores clocks
// R21 - eight clocks exchange one byte full duplex
// R22 - phase zero slave select toggles per byte
// R23 - lone second access leaves flag set
// R24 - status bits placed at fixed positions
//
// Register access over AHB-Lite was left to the implementer.
`include "spi_status_map.svh"
module spi_status_port (
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      hsel,
    input  wire logic [11:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output      logic [31:0]               hrdata,
    output      logic                      hreadyout,
    output      logic                      hresp,
    input  wire logic                      sclkIn,
    input  wire logic                      mosiIn,
    input  wire logic                      misoIn,
    input  wire logic                      slaveSelectN,
    output      spi_status_pkg::pin_out_t  pins,
    output      logic                      irq,
    output      logic                      selectIsGpio
);
    import spi_status_pkg::*;

    bus_req_t     req_r;
    logic [7:0]   ctrl_r;
    logic         error_irq_enable_r;
    logic         fdEn_r;
    logic [1:0]   baud_r;
    logic         rxFull_r;
    logic         ovr_r;
    logic         fault_r;
    logic         txEmpty_r;
    logic [7:0]   txData_r;
    logic [7:0]   rxData_r;
    logic [7:0]   shift_r;
    logic         txLoaded_r;
    logic         rxArm_r;
    logic         ovrArm_r;
    logic         faultArm_r;
    shift_state_t state_r;
    logic [3:0]   bitCnt_r;
    logic [7:0]   divCnt_r;
    logic         sclk_r;
    logic         ssPrev_r;
    logic         sclkPrev_r;
    logic [2:0]   syncPins;
    logic         sSclk;
    logic         sMosi;
    logic         sMiso;
    logic         sSsn;

    wire          enabled = ctrl_r[`CT_ENABLE];
    wire          master  = ctrl_r[`CT_MASTER];
    wire          cpol    = ctrl_r[`CT_CPOL];
    wire          clock_phase    = ctrl_r[`CT_CLOCK_PHASE];

    function automatic logic [7:0] divisor(input logic [1:0] code);
        unique case (code)
            2'h0: divisor = 8'h02;
            2'h1: divisor = 8'h08;
            2'h2: divisor = 8'h20;
            2'h3: divisor = 8'h80;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input logic [7:0] dummy);
        status_byte = dummy;
        status_byte[`ST_RXFULL]  = rxFull_r;
        status_byte[`ST_ERROR_IRQ_ENABLE]   = error_irq_enable_r;
        status_byte[`ST_OVR]     = ovr_r;
        status_byte[`ST_FAULT]   = fault_r;
        status_byte[`ST_TXEMPTY] = txEmpty_r;
        status_byte[`ST_FDEN]    = fdEn_r;
        status_byte[1:0]         = baud_r; // R24
    endfunction

    pin_sync #(
        .WIDTH (3),
        .INIT  (1'b1)
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .async_in ({sclkIn, mosiIn, slaveSelectN}),
        .sync_out (syncPins)
    );
    pin_sync #(
        .WIDTH (1),
        .INIT  (1'b0)
    ) u_sync_miso (
        .mclk     (mclk),
        .resetn   (resetn),
        .async_in (misoIn),
        .sync_out (sMiso)
    );
    assign sSclk = syncPins[2];
    assign sMosi = syncPins[1];
    assign sSsn  = syncPins[0];

    // bus request phase capture
    wire addrPhase = hsel && htrans[1] && hready;
    // armed in the cycle that captures the status value software will see
    wire rdStatus  = addrPhase && !hwrite && {haddr[11:2], 2'b00} == `STATUS_ADDR;
    wire rdData    = req_r.sel && !req_r.write && req_r.addr == `DATA_ADDR;
    wire wrCtrl    = req_r.sel && req_r.write && req_r.addr == `CTRL_ADDR;
    wire wrStatus  = req_r.sel && req_r.write && req_r.addr == `STATUS_ADDR;
    wire wrData    = req_r.sel && req_r.write && req_r.addr == `DATA_ADDR;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_r     <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            req_r.sel   <= addrPhase;
            req_r.write <= hwrite;
            req_r.addr  <= {haddr[11:2], 2'b00};
        end
    end

    // read data registered in the address phase, so it stands during the data phase
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            unique case ({haddr[11:2], 2'b00})
                `CTRL_ADDR:   hrdata <= {24'h000000, ctrl_r};
                `STATUS_ADDR: hrdata <= {24'h000000, status_byte(8'h00)};
                `DATA_ADDR:   hrdata <= {24'h000000, rxData_r}; // R17
                default:      hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // control and status writable fields
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r  <= `CTRL_RESET;
            error_irq_enable_r <= 1'b0; // R3
            fdEn_r  <= 1'b0;
            baud_r  <= `BAUD_RESET; // R15
        end else begin
            if (wrCtrl) begin
                ctrl_r <= hwdata[7:0];
            end
            if (wrStatus) begin
                error_irq_enable_r <= hwdata[`ST_ERROR_IRQ_ENABLE];
                fdEn_r  <= hwdata[`ST_FDEN];
                baud_r  <= hwdata[1:0];
            end
        end
    end

    // data registers hold their content through reset
    always_ff @(posedge mclk) begin
        if (wrData) begin
            txData_r <= hwdata[7:0]; // R17 R18
        end
    end

    // shift engine
    wire ssActive   = !sSsn;
    wire slaveSel   = enabled && !master && ssActive;
    wire slaveEdge  = sSclk != sclkPrev_r;
    wire leading    = slaveEdge && (sSclk != cpol);
    wire divDone    = divCnt_r == 8'h00;
    wire mstEdge    = master && enabled && state_r == ST_SHIFT && divDone;
    wire mstLeading = mstEdge && (sclk_r == cpol);
    wire sampleNow  = master ? (clock_phase ? !mstLeading && mstEdge : mstLeading)
                             : (slaveSel && (clock_phase ? slaveEdge && !leading : leading));
    wire byteDone   = state_r == ST_DONE;
    // a slave shifts whenever selected, fresh byte or not
    wire startXfer  = state_r == ST_IDLE && enabled && (master ? txLoaded_r : slaveSel);
    wire txHandoff  = startXfer && txLoaded_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= ST_IDLE;
            bitCnt_r   <= 4'h0;
            divCnt_r   <= 8'h00;
            sclk_r     <= 1'b0;
            sclkPrev_r <= 1'b0;
            ssPrev_r   <= 1'b1;
            txLoaded_r <= 1'b0;
            shift_r    <= 8'h00;
        end else begin
            sclkPrev_r <= sSclk;
            ssPrev_r   <= sSsn;
            if (wrData) begin
                txLoaded_r <= 1'b1;
            end
            unique case (state_r)
                ST_IDLE: begin
                    sclk_r <= cpol;
                    if (startXfer) begin
                        shift_r    <= txData_r;
                        txLoaded_r <= wrData;
                        bitCnt_r   <= 4'h0;
                        divCnt_r   <= divisor(baud_r) - 8'h01; // R15 R16
                        state_r    <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!enabled || (!master && !ssActive)) begin
                        state_r <= ST_IDLE; // R20
                    end else begin
                        if (master) begin
                            divCnt_r <= divDone ? divisor(baud_r) - 8'h01 : divCnt_r - 8'h01;
                            if (mstEdge) begin
                                sclk_r <= !sclk_r; // R16
                            end
                        end
                        if (sampleNow) begin
                            shift_r  <= {shift_r[6:0], master ? sMiso : sMosi};
                            bitCnt_r <= bitCnt_r + 4'h1;
                            if (bitCnt_r == `BITS_PER_BYTE - 4'h1) begin
                                state_r <= ST_DONE; // R21
                            end
                        end
                    end
                end
                ST_DONE: begin
                    sclk_r  <= cpol;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // receive register, overrun drops the newest byte
    always_ff @(posedge mclk) begin
        if (byteDone && !rxFull_r) begin
            rxData_r <= shift_r; // R1 R4 R18
        end
    end

    // receive full and overrun with two-step clear; a set wins over a clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rxFull_r <= 1'b0; // R2
            ovr_r    <= 1'b0; // R5
            rxArm_r  <= 1'b0;
            ovrArm_r <= 1'b0;
        end else begin
            if (rdStatus) begin
                rxArm_r  <= rxFull_r; // R23
                ovrArm_r <= ovr_r;
            end else if (rdData) begin
                rxArm_r  <= 1'b0;
                ovrArm_r <= 1'b0;
            end
            if (byteDone && !rxFull_r) begin
                rxFull_r <= 1'b1; // R1
            end else if (rdData && rxArm_r) begin
                rxFull_r <= 1'b0; // R2 R23
            end
            if (byteDone && rxFull_r) begin
                ovr_r <= 1'b1; // R4
            end else if (rdData && ovrArm_r) begin
                ovr_r <= 1'b0; // R5 R23
            end
        end
    end

    // mode fault; the enable gates only the set
    wire ssRose     = sSsn && !ssPrev_r;
    wire midByte    = state_r == ST_SHIFT && bitCnt_r != 4'h0; // rise between bytes is no fault
    wire faultSet   = enabled && fdEn_r &&
                      ((!master && ssRose && midByte) || // R6 R12 R14
                       (master && ssActive)); // R7 R13
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_r    <= 1'b0; // R8
            faultArm_r <= 1'b0;
        end else begin
            if (rdStatus) begin
                faultArm_r <= fault_r;
            end else if (wrCtrl) begin
                faultArm_r <= 1'b0;
            end
            if (faultSet) begin
                fault_r <= 1'b1; // R6 R7
            end else if (wrCtrl && faultArm_r) begin
                fault_r <= 1'b0; // R8 R12 R23
            end
        end
    end

    // transmit empty
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txEmpty_r <= 1'b1; // R10
        end else if (txHandoff) begin
            txEmpty_r <= 1'b1; // R9
        end else if (wrData) begin
            txEmpty_r <= 1'b0; // R10 R11
        end
    end

    // pins and request line, all registered
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pins         <= '0;
            irq          <= 1'b0;
            selectIsGpio <= 1'b1;
        end else begin
            pins.sclkOut <= sclk_r;
            pins.sclkOe  <= enabled && master;
            pins.mosiOut <= shift_r[7];
            pins.mosiOe  <= enabled && master;
            pins.misoOut <= shift_r[7];
            pins.misoOe  <= slaveSel; // R20
            selectIsGpio <= !enabled || (master && !fdEn_r); // R13 R14
            irq          <= (rxFull_r && ctrl_r[`CT_RXIE]) || // R1
                            (txEmpty_r && ctrl_r[`CT_TXIE]) || // R9
                            (error_irq_enable_r && (ovr_r || fault_r)); // R3
        end
    end

    a_rx_set: assert property (@(posedge mclk) disable iff (!resetn) // R1
        byteDone && !rxFull_r |=> rxFull_r && rxData_r == $past(shift_r))
        else $error("rx full not set on byte arrival");
    a_rx_clear: assert property (@(posedge mclk) disable iff (!resetn) // R2
        rdData && !rxArm_r && rxFull_r && !byteDone |=> rxFull_r)
        else $error("rx full cleared without status read");
    a_err_gate: assert property (@(posedge mclk) disable iff (!resetn) // R3
        !error_irq_enable_r && !rxFull_r && !txEmpty_r ##1 !error_irq_enable_r |-> !irq || $past(ctrl_r[`CT_RXIE]))
        else $error("error request leaked past enable");
    a_ovr_keep: assert property (@(posedge mclk) disable iff (!resetn) // R4
        byteDone && rxFull_r |=> ovr_r && $stable(rxData_r))
        else $error("overrun changed receive data");
    a_fault_master: assert property (@(posedge mclk) disable iff (!resetn) // R7
        enabled && master && fdEn_r && ssActive |=> fault_r)
        else $error("master fault not flagged");
    a_fault_keep: assert property (@(posedge mclk) disable iff (!resetn) // R12
        fault_r && !wrCtrl |=> fault_r)
        else $error("fault flag lost without control write");
    a_tx_clear: assert property (@(posedge mclk) disable iff (!resetn) // R10
        wrData && !txHandoff |=> !txEmpty_r)
        else $error("tx empty not cleared by data write");
    a_miso_float: assert property (@(posedge mclk) disable iff (!resetn) // R20
        sSsn [*2] |-> ##1 !pins.misoOe)
        else $error("deselected slave drives output");
endmodule

// ### testbench/spi_peer_model.sv
// far-side serial device: master or slave behaviour for the serial status block
module spi_peer_model (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire spi_status_pkg::pin_out_t pins,
    output      logic                     sclkIn,
    output      logic                     mosiIn,
    output      logic                     misoIn,
    output      logic                     slaveSelectN
);
    timeunit 1ns;
    timeprecision 1ns;
    import spi_status_pkg::*;
    logic [7:0] txb      = 8'hc3;
    logic [7:0] rxb      = 8'h00;
    int         fallCnt  = 0;
    int         halfSeen = 0;
    int         gapCnt   = 0;
    logic       lastClk  = 1'b0;

    initial begin
        sclkIn = 1'b0;
        mosiIn = 1'b0;
        misoIn = 1'b0;
        slaveSelectN = 1'b1;
    end

    // slave role, phase one: bit out on leading edge; capture there too, since the
    // master's bit then stands a full half period and changes with the trailing edge
    always @(posedge pins.sclkOut) begin
        if (resetn) begin
            misoIn <= txb[3'(7 - fallCnt)];
            rxb <= {rxb[6:0], pins.mosiOut};
        end
    end

    // bit count on trailing edge; line inverted after the byte so no stale bit is seen
    always @(negedge pins.sclkOut) begin
        if (resetn) begin
            fallCnt <= (fallCnt == 7) ? 0 : fallCnt + 1;
            if (fallCnt == 7) begin
                misoIn <= ~misoIn;
                txb <= txb + 8'h01;
            end
        end
    end

    // half period of the master clock in mclk cycles
    always @(posedge mclk) begin
        lastClk <= pins.sclkOut;
        gapCnt <= (pins.sclkOut != lastClk) ? 1 : gapCnt + 1;
        if (pins.sclkOut != lastClk) begin
            halfSeen <= gapCnt;
        end
    end

    // master role, phase one, clock idles low; stopAt 1 to 7 aborts mid-byte
    task automatic xfer(input logic [7:0] b, input int stopAt, input int half);
        @(posedge mclk);
        slaveSelectN <= 1'b0;
        for (int i = 0; i < 8 && i != stopAt; i++) begin
            repeat (half) @(posedge mclk);
            sclkIn <= 1'b1;
            mosiIn <= b[3'(7 - i)];
            repeat (half) @(posedge mclk);
            sclkIn <= 1'b0;
            rxb <= {rxb[6:0], pins.misoOe ? pins.misoOut : ~rxb[0]};
        end
        repeat (half) @(posedge mclk);
        slaveSelectN <= 1'b1;
        mosiIn <= ~mosiIn;
    endtask

    task automatic setSel(input logic v);
        @(posedge mclk);
        slaveSelectN <= v;
    endtask
endmodule

// ### testbench/tb_spi_status_port.sv
// self-checking bench for the serial status block over AHB-Lite
`include "spi_status_map.svh"
module tb_spi_status_port;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_status_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sclkIn;
    logic        mosiIn;
    logic        misoIn;
    logic        slaveSelectN;
    pin_out_t    pins;
    logic        irq;
    logic        selectIsGpio;
    int          fails = 0;
    int          compares = 0;
    int          bd[4] = '{2, 8, 32, 128};
    logic [7:0]  tx;
    logic [7:0]  exp;

    always #20 mclk = ~mclk;
    assign hready = hreadyout;

    spi_status_port dut_u (
        .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclkIn(sclkIn),
        .mosiIn(mosiIn), .misoIn(misoIn), .slaveSelectN(slaveSelectN), .pins(pins),
        .irq(irq), .selectIsGpio(selectIsGpio)
    );

    spi_peer_model peer_u (
        .mclk(mclk), .resetn(resetn), .pins(pins), .sclkIn(sclkIn), .mosiIn(mosiIn),
        .misoIn(misoIn), .slaveSelectN(slaveSelectN)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // single word transfer; waits on hready however long it takes
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata[7:0];
        chk({7'h00, hresp, hrdata[31:8]}, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic readCheck(input logic [11:0] a, input logic [7:0] m, input logic [7:0] w);
        logic [7:0] x;
        ahb(1'b0, a, 8'h00, x);
        chk({24'h0, x & m}, {24'h0, w});
    endtask

    // roughly 4.5k cycles expected; 50k leaves ample room
    initial begin
        #2000000;
        fails++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        readCheck(`STATUS_ADDR, 8'hff, 8'h08);
        readCheck(`CTRL_ADDR, 8'hff, 8'h28);
        readCheck(12'h04c, 8'hff, 8'h00);
        // slave side: peer is master at half period 8
        wr(`CTRL_ADDR, 8'h0a);
        wr(`DATA_ADDR, 8'h3c);
        repeat (4) @(posedge mclk);
        chk(pins.misoOe, 1'b0);
        peer_u.xfer(8'h96, 8, 8);
        repeat (8) @(posedge mclk);
        chk(peer_u.rxb, 8'h3c);
        readCheck(`STATUS_ADDR, 8'h88, 8'h88);
        readCheck(`DATA_ADDR, 8'hff, 8'h96);
        readCheck(`STATUS_ADDR, 8'h80, 8'h00);
        wr(`STATUS_ADDR, 8'h04);
        peer_u.xfer(8'h55, 3, 8);
        repeat (8) @(posedge mclk);
        readCheck(`STATUS_ADDR, 8'h10, 8'h10);
        wr(`CTRL_ADDR, 8'h0a);
        readCheck(`STATUS_ADDR, 8'h10, 8'h00);
        wr(`STATUS_ADDR, 8'h00);
        peer_u.xfer(8'h55, 3, 8);
        repeat (8) @(posedge mclk);
        readCheck(`STATUS_ADDR, 8'h10, 8'h00);
        // master side, select pin use and fault
        wr(`CTRL_ADDR, 8'h2a);
        repeat (4) @(posedge mclk);
        chk(selectIsGpio, 1'b1);
        chk({pins.sclkOe, pins.mosiOe}, 2'b11);
        wr(`STATUS_ADDR, 8'h04);
        repeat (4) @(posedge mclk);
        chk(selectIsGpio, 1'b0);
        peer_u.setSel(1'b0);
        repeat (8) @(posedge mclk);
        wr(`STATUS_ADDR, 8'h00);
        wr(`CTRL_ADDR, 8'h2a);
        readCheck(`STATUS_ADDR, 8'h10, 8'h10);
        wr(`CTRL_ADDR, 8'h2a);
        readCheck(`STATUS_ADDR, 8'h10, 8'h00);
        peer_u.setSel(1'b1);
        // every baud code; fast codes outrun the pin synchroniser, so their received byte is not compared
        for (int c = 0; c < 4; c++) begin
            wr(`STATUS_ADDR, 8'(c));
            tx = 8'h5a ^ 8'(c);
            exp = peer_u.txb;
            wr(`DATA_ADDR, tx);
            repeat (16 * bd[c] + 40) @(posedge mclk);
            chk(peer_u.halfSeen, bd[c]);
            chk(peer_u.rxb, tx);
            readCheck(`STATUS_ADDR, 8'h80, 8'h80);
            readCheck(`DATA_ADDR, c > 1 ? 8'hff : 8'h00, c > 1 ? exp : 8'h00);
            readCheck(`STATUS_ADDR, 8'h80, 8'h00);
        end
        // overrun: two bytes, receive register never read between them
        wr(`STATUS_ADDR, 8'h02);
        exp = peer_u.txb;
        wr(`DATA_ADDR, 8'h11);
        repeat (20) @(posedge mclk);
        wr(`DATA_ADDR, 8'h22);
        readCheck(`STATUS_ADDR, 8'h88, 8'h00);
        repeat (1100) @(posedge mclk);
        readCheck(`DATA_ADDR, 8'hff, exp);
        wr(`STATUS_ADDR, 8'h42);
        repeat (4) @(posedge mclk);
        chk(irq, 1'b1);
        wr(`STATUS_ADDR, 8'h02);
        repeat (4) @(posedge mclk);
        chk(irq, 1'b0);
        readCheck(`STATUS_ADDR, 8'hff, 8'haa);
        readCheck(`DATA_ADDR, 8'hff, exp);
        readCheck(`STATUS_ADDR, 8'hff, 8'h0a);
        // second reset keeps the receive byte
        resetn <= 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        readCheck(`DATA_ADDR, 8'hff, exp);
        readCheck(`STATUS_ADDR, 8'hff, 8'h08);
        end_of_test();
    end
endmodule
